// ==== verilog/secure_cmd_pkg.sv ====
// Constants, field layouts and state codes for the secure verify command logic.
// Assumes a byte link that delivers the five-byte header CLA INS P1 P2 P3 first.
package secure_cmd_pkg;
   localparam logic [7:0] INS_SYS_READ      = 8'hB6;
   localparam logic [7:0] INS_VERIFY_CRYPTO = 8'hB8;
   localparam logic [7:0] INS_VERIFY_PW     = 8'hBA;
   localparam logic [7:0] SYSRD_FUSE        = 8'h01;
   localparam logic [7:0] SYSRD_CHECKSUM    = 8'h02;
   localparam logic [7:0] CHECKSUM_LEN      = 8'h02;
   localparam logic [7:0] SW_OK_HI          = 8'h90;
   localparam logic [7:0] SW_DENY_HI        = 8'h69;
   localparam logic [7:0] SW_LO             = 8'h00;
   localparam logic [3:0] FUSE_RESV         = 4'h0;
   localparam int         FUSE_FACTORY_BIT  = 0;
   localparam int         FUSE_ASSEMBLY_BIT = 1;
   localparam int         FUSE_PERSO_BIT    = 2;
   localparam int         FUSE_STATE_BIT    = 3;
   localparam logic [5:0] KEY_SEED_PAT      = 6'h00;
   localparam logic [5:0] KEY_SESSION_PAT   = 6'h04;
   localparam logic [2:0] PW_PAT_MASKED     = 3'h0;
   localparam int         PW_READ_BIT       = 4;
   localparam logic [2:0] SECURE_CODE_SET   = 3'h7;
   localparam logic [4:0] CRYPTO_DATA_LEN   = 5'h10;
   localparam logic [4:0] PW_DATA_LEN       = 5'h03;
   localparam logic [2:0] HDR_LAST          = 3'h4;
   localparam logic [3:0] KEY_TRIAL_LIMIT   = 4'h8;
   localparam logic [3:0] PW_TRIAL_FULL     = 4'h8;

   typedef enum logic [2:0] {
      S_HDR    = 3'b000,
      S_DECODE = 3'b001,
      S_ECHO   = 3'b010,
      S_RECV   = 3'b011,
      S_COUNT  = 3'b100,
      S_CHECK  = 3'b101,
      S_REPLY  = 3'b110,
      S_DONE   = 3'b111
   } cmd_state_e;
endpackage

// ==== verilog/byte_link_if.sv ====
// Byte stream between the link shifter and the command interpreter.
// Assumes both ends run on mclk.
`timescale 1ns/10ps
interface byte_link_if;
   logic       frame_active;
   logic       rx_valid;
   logic [7:0] rx_byte;
   logic       tx_valid;
   logic [7:0] tx_byte;
   logic       tx_ready;
   modport shifter (output frame_active, output rx_valid, output rx_byte,
                    input tx_valid, input tx_byte, output tx_ready);
   modport cmd (input frame_active, input rx_valid, input rx_byte,
                output tx_valid, output tx_byte, input tx_ready);
endinterface

// ==== verilog/link_shifter.sv ====
// Serial byte shifter on a host-made link clock, sampled by mclk.
// Assumes the link is half duplex and the host only drives data while the device does not.
`timescale 1ns/10ps
module link_shifter (
   input  wire logic   mclk,
   input  wire logic   sys_rst,
   input  wire logic   link_clk,
   input  wire logic   link_frame,
   input  wire logic   link_data_in,
   output logic        link_data_out,
   output logic        link_data_oe,
   byte_link_if.shifter lk
);
   logic [2:0] clk_sync;
   logic [1:0] frame_sync;
   logic [1:0] data_sync;
   logic       clk_rise;
   logic       clk_fall;
   logic [7:0] rx_shift;
   logic [2:0] rx_count;
   logic [7:0] tx_shift;
   logic [3:0] tx_left;

   ////////////////////////////////////////////////////////////////////////////////
   // The first stage of each synchroniser feeds only the second stage.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         clk_sync   <= 3'h0;
         frame_sync <= 2'h0;
         data_sync  <= 2'h0;
      end else begin
         clk_sync   <= {clk_sync[1:0], link_clk};
         frame_sync <= {frame_sync[0], link_frame};
         data_sync  <= {data_sync[0], link_data_in};
      end
   end

   assign clk_rise        = clk_sync[1] & ~clk_sync[2];
   assign clk_fall        = ~clk_sync[1] & clk_sync[2];
   assign lk.frame_active = frame_sync[1];
   assign lk.tx_ready     = frame_sync[1] && (tx_left == 4'h0);

   ////////////////////////////////////////////////////////////////////////////////
   // Receive: bits are taken on rising link edges while the device is not talking.
   always_ff @(posedge mclk) begin
      if (sys_rst || !frame_sync[1]) begin
         rx_shift    <= 8'h00;
         rx_count    <= 3'h0;
         lk.rx_valid <= 1'b0;
         lk.rx_byte  <= 8'h00;
      end else begin
         lk.rx_valid <= 1'b0;
         if (clk_rise && tx_left == 4'h0) begin
            rx_shift <= {rx_shift[6:0], data_sync[1]};
            rx_count <= rx_count + 3'h1;
            if (rx_count == 3'h7) begin
               lk.rx_valid <= 1'b1;
               lk.rx_byte  <= {rx_shift[6:0], data_sync[1]};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Transmit: MSB first, the first bit driven at load and each later bit changed on a falling edge so it is steady at the rise.
   always_ff @(posedge mclk) begin
      if (sys_rst || !frame_sync[1]) begin
         tx_shift      <= 8'h00;
         tx_left       <= 4'h0;
         link_data_out <= 1'b0;
         link_data_oe  <= 1'b0;
      end else if (lk.tx_valid && tx_left == 4'h0) begin
         // A byte loaded while the link clock is high keeps its first bit over the next fall.
         tx_shift      <= lk.tx_byte;
         tx_left       <= clk_sync[1] ? 4'h9 : 4'h8;
         link_data_out <= lk.tx_byte[7];
         link_data_oe  <= 1'b1;
      end else if (clk_fall && tx_left == 4'h9) begin
         tx_left       <= 4'h8;
      end else if (clk_fall && tx_left != 4'h0) begin
         tx_shift      <= {tx_shift[6:0], 1'b0};
         tx_left       <= tx_left - 4'h1;
         link_data_out <= tx_shift[6];
         link_data_oe  <= (tx_left != 4'h1);
      end
   end
endmodule

// ==== verilog/secure_verify_commands.sv ====
// Command interpreter for fuse read, checksum read, challenge verify and password verify.
// Assumes an external cipher, nonvolatile attempt counters and password storage.
`timescale 1ns/10ps
module secure_verify_commands
   import secure_cmd_pkg::*;
#(
   parameter logic [3:0] KEY_LIMIT = KEY_TRIAL_LIMIT,
   parameter logic [3:0] PW_FULL   = PW_TRIAL_FULL
) (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        link_clk,
   input  wire logic        link_frame,
   input  wire logic        link_data_in,
   output logic             link_data_out,
   output logic             link_data_oe,
   input  wire logic [3:0]  fuse_state,
   input  wire logic [15:0] checksum,
   input  wire logic [15:0] key_attempts,
   input  wire logic [63:0] pw_attempts,
   output logic             counter_wr,
   output logic             counter_is_pw,
   output logic [3:0]       counter_idx,
   output logic [3:0]       counter_value,
   output logic [3:0]       pw_sel,
   input  wire logic [23:0] pw_ref,
   output logic             crypto_req,
   output logic [2:0]       crypto_key_sel,
   output logic [63:0]      crypto_random,
   output logic [63:0]      host_challenge_bytes,
   input  wire logic        crypto_done,
   input  wire logic        crypto_match,
   output logic             crypto_commit,
   output logic [3:0]       auth_priv,
   output logic [7:0]       read_priv,
   output logic [7:0]       write_priv,
   output logic             config_write_allowed,
   output logic [7:0]       security_fuse_status
);
   byte_link_if lk ();

   link_shifter u_link (
      .mclk          (mclk),
      .sys_rst       (sys_rst),
      .link_clk      (link_clk),
      .link_frame    (link_frame),
      .link_data_in  (link_data_in),
      .link_data_out (link_data_out),
      .link_data_oe  (link_data_oe),
      .lk            (lk)
   );

   cmd_state_e  state;
   logic [7:0]  hdr [0:4];
   logic [2:0]  hdr_cnt;
   logic [4:0]  data_cnt;
   logic [4:0]  data_len;
   logic [127:0] data_buf;
   logic [7:0]  reply_buf [0:3];
   logic [2:0]  reply_len;
   logic [2:0]  reply_pos;
   logic        is_crypto;
   logic        verdict_ok;
   logic        verdict_now;
   logic [3:0]  key_count;
   logic [3:0]  pw_count;
   logic        key_idx_ok;
   logic        pw_idx_ok;
   logic [23:0] password_byte_low_first;

   ////////////////////////////////////////////////////////////////////////////////
   // Decode of the parameter byte and lookup of the stored counters.
   assign key_idx_ok = (hdr[2][7:2] == KEY_SEED_PAT) || (hdr[2][7:2] == KEY_SESSION_PAT);
   assign pw_idx_ok  = (hdr[2][7:5] == 3'h0) && (hdr[2][3] == 1'b0);
   assign key_count  = key_attempts[{hdr[2][1:0], 2'b00} +: 4];
   assign pw_count   = pw_attempts[{pw_sel, 2'b00} +: 4];
   // PW1 arrives first and is the low byte of the 24-bit password.
   assign password_byte_low_first = {data_buf[7:0], data_buf[15:8], data_buf[23:16]};
   assign lk.tx_valid = (state == S_ECHO) || (state == S_REPLY);
   assign lk.tx_byte  = (state == S_ECHO) ? hdr[1] : reply_buf[reply_pos[1:0]];

   assign security_fuse_status = {FUSE_RESV,
                                  fuse_state[FUSE_STATE_BIT], fuse_state[FUSE_PERSO_BIT],
                                  fuse_state[FUSE_ASSEMBLY_BIT], fuse_state[FUSE_FACTORY_BIT]};

   // Verdict of the compare; the password compare runs after its counter write.
   always_comb begin
      verdict_now = 1'b0;
      verdict_ok  = 1'b0;
      if (state == S_CHECK) begin
         if (is_crypto) begin
            verdict_now = crypto_done;
            verdict_ok  = crypto_match;
         end else begin
            verdict_now = 1'b1;
            verdict_ok  = (password_byte_low_first == pw_ref);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Command sequencing; a dropped frame always returns to header collection.
   always_ff @(posedge mclk) begin
      if (sys_rst || !lk.frame_active) begin
         state     <= S_HDR;
         hdr_cnt   <= 3'h0;
         data_cnt  <= 5'h00;
         data_len  <= 5'h00;
         data_buf  <= 128'h0;
         reply_len <= 3'h0;
         reply_pos <= 3'h0;
         is_crypto <= 1'b0;
         pw_sel    <= 4'h0;
         for (int i = 0; i < 5; i++) hdr[i] <= 8'h00;
         for (int i = 0; i < 4; i++) reply_buf[i] <= 8'h00;
      end else begin
         case (state)
            S_HDR: begin
               if (lk.rx_valid) begin
                  hdr[hdr_cnt] <= lk.rx_byte;
                  hdr_cnt      <= hdr_cnt + 3'h1;
                  if (hdr_cnt == HDR_LAST) state <= S_DECODE;
               end
            end
            S_DECODE: begin
               reply_pos    <= 3'h0;
               reply_len    <= 3'h2;
               reply_buf[0] <= SW_DENY_HI;
               reply_buf[1] <= SW_LO;
               state        <= S_REPLY;
               pw_sel       <= {hdr[2][PW_READ_BIT], hdr[2][2:0]};
               if (hdr[1] == INS_SYS_READ && hdr[2] == SYSRD_FUSE) begin
                  reply_buf[0] <= security_fuse_status;
                  reply_buf[1] <= SW_OK_HI;
                  reply_buf[2] <= SW_LO;
                  reply_len    <= 3'h3;
                  state        <= S_ECHO;
               end else if (hdr[1] == INS_SYS_READ && hdr[2] == SYSRD_CHECKSUM) begin
                  // Always two checksum bytes, whatever length the host asked for.
                  reply_buf[0] <= checksum[15:8];
                  reply_buf[1] <= checksum[7:0];
                  reply_buf[2] <= SW_OK_HI;
                  reply_buf[3] <= SW_LO;
                  reply_len    <= 3'h4;
                  state        <= S_ECHO;
               end else if (hdr[1] == INS_VERIFY_CRYPTO && key_idx_ok &&
                            key_count < KEY_LIMIT) begin
                  is_crypto <= 1'b1;
                  data_len  <= CRYPTO_DATA_LEN;
                  state     <= S_ECHO;
               end else if (hdr[1] == INS_VERIFY_PW && pw_idx_ok &&
                            pw_attempts[{hdr[2][PW_READ_BIT], hdr[2][2:0], 2'b00} +: 4]
                            != 4'h0) begin
                  is_crypto <= 1'b0;
                  data_len  <= PW_DATA_LEN;
                  state     <= S_ECHO;
               end
            end
            S_ECHO: begin
               if (lk.tx_ready) state <= (data_len == 5'h00) ? S_REPLY : S_RECV;
            end
            S_RECV: begin
               if (lk.rx_valid) begin
                  data_buf <= {data_buf[119:0], lk.rx_byte};
                  data_cnt <= data_cnt + 5'h01;
                  if (data_cnt == data_len - 5'h01) state <= S_COUNT;
               end
            end
            S_COUNT: state <= S_CHECK;
            S_CHECK: begin
               if (verdict_now) begin
                  reply_buf[0] <= verdict_ok ? SW_OK_HI : SW_DENY_HI;
                  reply_buf[1] <= SW_LO;
                  reply_len    <= 3'h2;
                  reply_pos    <= 3'h0;
                  state        <= S_REPLY;
               end
            end
            S_REPLY: begin
               if (lk.tx_ready) begin
                  reply_pos <= reply_pos + 3'h1;
                  if (reply_pos == reply_len - 3'h1) state <= S_DONE;
               end
            end
            S_DONE: state <= S_DONE;
            default: state <= S_HDR;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Counter updates go out before any compare so a lost supply still counts the try.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         counter_wr    <= 1'b0;
         counter_is_pw <= 1'b0;
         counter_idx   <= 4'h0;
         counter_value <= 4'h0;
      end else begin
         counter_wr <= 1'b0;
         if (state == S_COUNT) begin
            counter_wr    <= 1'b1;
            counter_is_pw <= !is_crypto;
            counter_idx   <= is_crypto ? {2'b00, hdr[2][1:0]} : pw_sel;
            counter_value <= is_crypto ? key_count + 4'h1 : pw_count - 4'h1;
         end else if (verdict_now && verdict_ok) begin
            counter_wr    <= 1'b1;
            counter_value <= is_crypto ? 4'h0 : PW_FULL;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Cipher request and commit of the new cryptogram and session key.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         crypto_req           <= 1'b0;
         crypto_commit        <= 1'b0;
         crypto_key_sel       <= 3'h0;
         crypto_random        <= 64'h0;
         host_challenge_bytes <= 64'h0;
      end else begin
         crypto_req    <= (state == S_COUNT) && is_crypto;
         crypto_commit <= verdict_now && verdict_ok && is_crypto;
         if (state == S_COUNT) begin
            crypto_key_sel       <= {hdr[2][4], hdr[2][1:0]};
            crypto_random        <= data_buf[127:64];
            host_challenge_bytes <= data_buf[63:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Volatile privileges; they are lost at reset so a fresh session must verify again.
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         auth_priv  <= 4'h0;
         read_priv  <= 8'h00;
         write_priv <= 8'h00;
      end else if (verdict_now && verdict_ok) begin
         if (is_crypto) auth_priv[hdr[2][1:0]] <= 1'b1;
         else if (pw_sel[3]) read_priv[pw_sel[2:0]] <= 1'b1;
         else write_priv[pw_sel[2:0]] <= 1'b1;
      end
   end

   assign config_write_allowed = write_priv[SECURE_CODE_SET];
endmodule

// ==== verif/secure_verify_chk.sv ====
// Concurrent checks on the ports of the secure verify command logic.
// Assumes one mclk domain with synchronous active-high reset; bound below.
`timescale 1ns/10ps
module secure_verify_chk
   import secure_cmd_pkg::*;
#(
   parameter logic [3:0] KEY_LIMIT = KEY_TRIAL_LIMIT,
   parameter logic [3:0] PW_FULL   = PW_TRIAL_FULL
) (
   input wire logic        mclk,
   input wire logic        sys_rst,
   input wire logic [3:0]  fuse_state,
   input wire logic [7:0]  security_fuse_status,
   input wire logic [15:0] key_attempts,
   input wire logic [63:0] pw_attempts,
   input wire logic        counter_wr,
   input wire logic        counter_is_pw,
   input wire logic [3:0]  counter_idx,
   input wire logic [3:0]  counter_value,
   input wire logic        crypto_req,
   input wire logic [2:0]  crypto_key_sel,
   input wire logic        crypto_commit,
   input wire logic [3:0]  auth_priv,
   input wire logic [7:0]  read_priv,
   input wire logic [7:0]  write_priv,
   input wire logic        config_write_allowed
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   logic grant7;
   // A reload of write counter 7 is the only event that may open configuration writes.
   assign grant7 = counter_wr && counter_is_pw && counter_idx == 4'h7 && counter_value == PW_FULL;
   ////////////////////////////////////////////////////////////////////////////////
   a_fuse_map: assert property (security_fuse_status[3:0] == fuse_state)
      else $error("fuse bits differ from fuse cells");
   a_fuse_resv: assert property (security_fuse_status[7:4] == 4'h0)
      else $error("reserved fuse bits not zero");
   a_key_count_first: assert property (crypto_req |-> counter_wr && !counter_is_pw
      && counter_value == key_attempts[{counter_idx[1:0], 2'b00} +: 4] + 4'h1)
      else $error("key counter not bumped with the cipher request");
   a_key_select: assert property (crypto_req |-> crypto_key_sel[1:0] == counter_idx[1:0])
      else $error("key select and counter index disagree");
   a_commit_clear: assert property (crypto_commit |-> counter_wr && !counter_is_pw
      && counter_value == 4'h0)
      else $error("commit without key counter clear");
   a_auth_cause: assert property (!$past(sys_rst) && auth_priv != $past(auth_priv)
      |-> crypto_commit || $past(crypto_commit))
      else $error("auth flags changed without a commit");
   a_pw_count_dec: assert property (counter_wr && counter_is_pw && counter_value != PW_FULL
      |-> counter_value == pw_attempts[{counter_idx, 2'b00} +: 4] - 4'h1)
      else $error("password counter not decremented");
   a_write_grant: assert property ($rose(write_priv[7]) |-> grant7 || $past(grant7))
      else $error("write flag 7 set without a reload");
   a_cfg_gate: assert property (config_write_allowed == write_priv[7])
      else $error("config gate not following write flag 7");
   a_priv_reset: assert property ($fell(sys_rst) |-> auth_priv == 4'h0 && read_priv == 8'h00
      && write_priv == 8'h00)
      else $error("flags not clear after reset");
endmodule
bind secure_verify_commands secure_verify_chk #(.KEY_LIMIT(KEY_LIMIT), .PW_FULL(PW_FULL)) chk (
   .mclk(mclk), .sys_rst(sys_rst), .fuse_state(fuse_state),
   .security_fuse_status(security_fuse_status), .key_attempts(key_attempts),
   .pw_attempts(pw_attempts), .counter_wr(counter_wr), .counter_is_pw(counter_is_pw),
   .counter_idx(counter_idx), .counter_value(counter_value), .crypto_req(crypto_req),
   .crypto_key_sel(crypto_key_sel), .crypto_commit(crypto_commit), .auth_priv(auth_priv),
   .read_priv(read_priv), .write_priv(write_priv), .config_write_allowed(config_write_allowed));

// ==== verif/host_link_model.sv ====
// Host end of the serial command link: frames, bytes sent and bytes read back.
// Assumes a pull-up on the data line; the clock stands low outside frames.
`timescale 1ns/10ps
module host_link_model (
   output logic      link_clk,
   output logic      link_frame,
   output logic      link_data_in,
   input  wire logic link_data_out,
   input  wire logic link_data_oe
);
   logic hdrv = 1'b0;
   logic hbit = 1'b1;
   // Released line floats high, so a stale bit can never pass for data.
   assign link_data_in = link_data_oe ? link_data_out : (hdrv ? hbit : 1'b1);
   initial begin
      link_clk = 1'b0;
      link_frame = 1'b0;
   end
   task automatic start();
      link_frame = 1'b1;
      #80;
   endtask
   task automatic tx(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         link_clk = 1'b0;
         #48;
         hdrv = 1'b1;
         hbit = b[i];
         #32;
         link_clk = 1'b1;
         #80;
      end
   endtask
   task automatic rx(output logic [7:0] b);
      hdrv = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         link_clk = 1'b0;
         #80;
         b[i] = link_data_in;
         link_clk = 1'b1;
         #80;
      end
   endtask
   task automatic stop();
      link_clk = 1'b0;
      #80;
      link_frame = 1'b0;
      #160;
   endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the secure verify command logic.
// Assumes the host link model beside it; counters and cipher are modelled here.
`timescale 1ns/10ps
module testbench import secure_cmd_pkg::*;;
   typedef struct {
      logic [7:0]   ins;
      logic [7:0]   p1;
      logic [7:0]   p3;
      int           nd;
      logic [127:0] d;
      int           nr;
      logic [7:0]   echo;
      logic [31:0]  rep;
   } row_s;
   localparam logic [63:0] RND = 64'h0123456789ABCDEF;
   logic        mclk, sys_rst, link_clk, link_frame, link_data_in, link_data_out, link_data_oe;
   logic [3:0]  fuse_state, counter_idx, counter_value, pw_sel, auth_priv;
   logic [15:0] checksum, key_attempts;
   logic [63:0] pw_attempts, crypto_random, host_challenge_bytes;
   logic        counter_wr, counter_is_pw, crypto_req, crypto_done, crypto_match, crypto_commit;
   logic [23:0] pw_ref;
   logic [2:0]  crypto_key_sel;
   logic [7:0]  read_priv, write_priv, security_fuse_status, echo;
   logic        config_write_allowed;
   logic [31:0] rep;
   int          num_errors = 0, compares = 0, lat = 3, wait_cnt = 0;
   row_s        rows[10];
   always #4 mclk = ~mclk;
   secure_verify_commands dut (.mclk(mclk), .sys_rst(sys_rst), .link_clk(link_clk),
      .link_frame(link_frame), .link_data_in(link_data_in), .link_data_out(link_data_out),
      .link_data_oe(link_data_oe), .fuse_state(fuse_state), .checksum(checksum),
      .key_attempts(key_attempts), .pw_attempts(pw_attempts), .counter_wr(counter_wr),
      .counter_is_pw(counter_is_pw), .counter_idx(counter_idx), .counter_value(counter_value),
      .pw_sel(pw_sel), .pw_ref(pw_ref), .crypto_req(crypto_req), .crypto_key_sel(crypto_key_sel),
      .crypto_random(crypto_random), .host_challenge_bytes(host_challenge_bytes),
      .crypto_done(crypto_done), .crypto_match(crypto_match), .crypto_commit(crypto_commit),
      .auth_priv(auth_priv), .read_priv(read_priv), .write_priv(write_priv),
      .config_write_allowed(config_write_allowed), .security_fuse_status(security_fuse_status));
   host_link_model host (.link_clk(link_clk), .link_frame(link_frame),
      .link_data_in(link_data_in), .link_data_out(link_data_out), .link_data_oe(link_data_oe));
   ////////////////////////////////////////////////////////////////////////////////
   // Stored passwords depend on the selection so a wrong set can never match.
   assign pw_ref = {8'hC0, 8'h5E, 4'hA, pw_sel};
   // Nonvolatile counters live here; the bench may also preload them directly.
   always @(posedge mclk) begin
      if (counter_wr && counter_is_pw) pw_attempts[{counter_idx, 2'b00} +: 4] <= counter_value;
      else if (counter_wr) key_attempts[{counter_idx[1:0], 2'b00} +: 4] <= counter_value;
   end
   // Toy cipher: a challenge matches when it is the inverse of the random.
   always @(posedge mclk) begin
      if (crypto_req) wait_cnt <= lat;
      else if (wait_cnt > 0) wait_cnt <= wait_cnt - 1;
      crypto_done <= (wait_cnt == 1) && !crypto_req;
      crypto_match <= host_challenge_bytes == ~crypto_random;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic run_cmd(input logic [7:0] ins, input logic [7:0] p1, input logic [7:0] p3,
         input int nd, input logic [127:0] d, input int nr, output logic [7:0] e,
         output logic [31:0] r);
      logic [7:0]  b;
      logic [39:0] hdr;
      hdr = {8'h00, ins, p1, 8'h00, p3};
      r = '0;
      // The host moves just off the mclk edge so its changes never race the synchronisers.
      @(posedge mclk);
      #2;
      host.start();
      for (int i = 4; i >= 0; i--) host.tx(hdr[8*i +: 8]);
      host.rx(e);
      if (e === ins) begin
         for (int i = nd - 1; i >= 0; i--) host.tx(d[8*i +: 8]);
         if (nd > 0) #1000;
      end else nr = 1;
      for (int i = 0; i < nr; i++) begin
         host.rx(b);
         r = {r[23:0], b};
      end
      host.stop();
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      sys_rst = 1'b1;
      fuse_state = 4'hA;
      checksum = 16'hC35A;
      key_attempts = 16'h0000;
      pw_attempts = {16{4'h8}};
      rows = '{
         '{8'hB6, 8'h01, 8'h01, 0, '0, 3, 8'hB6, 32'h000A9000},
         '{8'hB6, 8'h02, 8'h02, 0, '0, 4, 8'hB6, 32'hC35A9000},
         '{8'hB0, 8'h00, 8'h00, 0, '0, 1, 8'h69, 32'h0},
         '{8'hB8, 8'h08, 8'h10, 16, '0, 2, 8'h69, 32'h0},
         '{8'hBA, 8'h08, 8'h03, 3, '0, 2, 8'h69, 32'h0},
         '{8'hBA, 8'h10, 8'h03, 3, 128'hA85EC0, 2, 8'hBA, 32'h9000},
         '{8'hBA, 8'h03, 8'h03, 3, 128'h0, 2, 8'hBA, 32'h6900},
         '{8'hB8, 8'h00, 8'h10, 16, {RND, ~RND}, 2, 8'hB8, 32'h9000},
         '{8'hB8, 8'h13, 8'h10, 16, {RND, RND}, 2, 8'hB8, 32'h6900},
         '{8'hBA, 8'h07, 8'h03, 3, 128'hA75EC0, 2, 8'hBA, 32'h9000}};
      repeat (10) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge mclk);
      check(32'(config_write_allowed), 32'h0, "config open early");
      foreach (rows[i]) begin
         run_cmd(rows[i].ins, rows[i].p1, rows[i].p3, rows[i].nd, rows[i].d, rows[i].nr, echo, rep);
         check(32'(echo), 32'(rows[i].echo), "first reply");
         check(rep, rows[i].rep, "status");
      end
      check(32'(pw_attempts[12 +: 4]), 32'h7, "wrong password count");
      check(32'(pw_attempts[32 +: 4]), 32'(PW_TRIAL_FULL), "password reload");
      check(32'(key_attempts), 32'h1000, "key counts");
      check(32'({auth_priv, read_priv, write_priv}), 32'h10180, "flags");
      check(32'(config_write_allowed), 32'h1, "config open");
      @(posedge mclk);
      pw_attempts[8 +: 4] <= 4'h0;
      key_attempts[4 +: 4] <= KEY_TRIAL_LIMIT;
      @(posedge mclk);
      run_cmd(8'hBA, 8'h02, 8'h03, 3, 128'hA25EC0, 2, echo, rep);
      check(32'({echo, rep[7:0]}), 32'h6900, "spent password");
      check(32'(pw_attempts[8 +: 4]), 32'h0, "spent count kept");
      run_cmd(8'hB8, 8'h01, 8'h10, 16, {RND, ~RND}, 2, echo, rep);
      check(32'({echo, rep[7:0]}), 32'h6900, "spent key");
      lat = 60;
      run_cmd(8'hB8, 8'h12, 8'h10, 16, {RND, ~RND}, 2, echo, rep);
      check(rep, 32'h9000, "slow cipher");
      check(32'(auth_priv), 32'h5, "auth flags");
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      repeat (5) @(posedge mclk);
      check(32'({auth_priv, read_priv, write_priv}), 32'h0, "flags after reset");
      check(32'(key_attempts[15:12]), 32'h1, "count kept over reset");
      end_of_test();
   end
   initial begin
      #400000;
      num_errors++;
      $display("MISMATCH at %0t: watchdog expired", $time);
      end_of_test();
   end
endmodule
